// ==== verilog/wol_pkg.sv ====
// package: constants and carriers for the window offset and limit-clear block
package wol_pkg;
	localparam int WOL_NUM_WIN = 2;
	localparam int WOL_VAL_W = 32;
	localparam int WOL_TALLY_W = 16;
	localparam int WOL_FRAC_BITS = 10;
	// offset magnitude in milli-dB, signed
	localparam logic signed [WOL_VAL_W-1:0] WOL_OFS_MIN = -32'sd100000;
	localparam logic signed [WOL_VAL_W-1:0] WOL_OFS_MAX = 32'sd100000;
	localparam logic signed [WOL_VAL_W-1:0] WOL_OFS_RST = 32'sd0;
	localparam logic [7:0] WOL_SPEED_CONFLICT = 8'hC8;
	localparam logic signed [15:0] WOL_ERR_CONFLICT = -16'sd221;
	localparam logic signed [15:0] WOL_ERR_NONE = 16'sd0;
	localparam logic [WOL_TALLY_W-1:0] WOL_TALLY_RST = 16'h0000;

	// auto-clear mode
	typedef enum logic [1:0] {
		WOL_AC_OFF = 2'b00,
		WOL_AC_ON = 2'b01,
		WOL_AC_ONCE = 2'b10
	} wol_ac_t;

	// command codes
	typedef enum logic [3:0] {
		WOL_CMD_NONE = 4'h0,
		WOL_CMD_OFS_SET = 4'h1,
		WOL_CMD_OFS_EN = 4'h2,
		WOL_CMD_AC_SET = 4'h3,
		WOL_CMD_CLR_NOW = 4'h4,
		WOL_CMD_LIM_EN = 4'h5,
		WOL_CMD_LIM_LO = 4'h6,
		WOL_CMD_LIM_HI = 4'h7
	} wol_cmd_code_t;

	// decoded command presented to the block
	typedef struct packed {
		logic valid;
		logic win;
		wol_cmd_code_t code;
		logic signed [WOL_VAL_W-1:0] value;
	} wol_cmd_t;

	// one measurement result for a window
	typedef struct packed {
		logic valid;
		logic win;
		logic start;
		logic signed [WOL_VAL_W-1:0] value;
	} wol_meas_t;

	// query answers of one window
	typedef struct packed {
		logic signed [WOL_VAL_W-1:0] ofs_mag;
		logic ofs_en;
		logic ac_query;
		logic fail;
		logic [WOL_TALLY_W-1:0] tally;
		logic signed [WOL_VAL_W-1:0] shown;
	} wol_status_t;

	// per-window state
	typedef struct packed {
		logic signed [WOL_VAL_W-1:0] ofs_mag;
		logic ofs_en;
		wol_ac_t ac_mode;
		logic once_armed;
		logic lim_en;
		logic signed [WOL_VAL_W-1:0] lim_lo;
		logic signed [WOL_VAL_W-1:0] lim_hi;
		logic [WOL_TALLY_W-1:0] tally;
		logic signed [WOL_VAL_W-1:0] shown;
		logic ttl;
	} wol_win_state_t;

	localparam logic signed [WOL_VAL_W-1:0] WOL_LIM_LO_RST = -32'sd90000;
	localparam logic signed [WOL_VAL_W-1:0] WOL_LIM_HI_RST = 32'sd90000;
endpackage

// ==== verilog/wol_window.sv ====
// one window: offset stage, limit test and fail tally
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wol_window
	import wol_pkg::*;
#(
	parameter int TALLY_W = WOL_TALLY_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmd_stb_i,
	input wire wol_cmd_code_t cmd_code_i,
	input wire logic signed [WOL_VAL_W-1:0] cmd_value_i,
	input wire logic speed_conflict_i,
	input wire logic meas_stb_i,
	input wire logic meas_start_i,
	input wire logic signed [WOL_VAL_W-1:0] meas_value_i,
	output logic err_stb_o,
	output wol_status_t status_o,
	output logic ttl_o
);
	if (TALLY_W != WOL_TALLY_W) begin : g_bad_width
		$error("tally width must equal package width");
	end

	wol_win_state_t st;
	wol_win_state_t next_st;
	logic next_err;
	logic err;
	logic signed [WOL_VAL_W-1:0] adj;
	logic outside;
	logic fail_now;

	assign fail_now = st.lim_en && outside;

	function automatic logic signed [WOL_VAL_W-1:0] clamp_ofs(input logic signed [WOL_VAL_W-1:0] v);
		if (v < WOL_OFS_MIN) return WOL_OFS_MIN;
		if (v > WOL_OFS_MAX) return WOL_OFS_MAX;
		return v;
	endfunction

	always_comb begin
		next_st = st;
		next_err = 1'b0;
		// offset after math result
		adj = st.ofs_en ? meas_value_i + st.ofs_mag : meas_value_i;
		outside = (adj < st.lim_lo) || (adj > st.lim_hi);
		if (cmd_stb_i) begin
			case (cmd_code_i)
				WOL_CMD_OFS_SET: begin
					if (speed_conflict_i) begin
						next_err = 1'b1;
					end else begin
						next_st.ofs_mag = clamp_ofs(cmd_value_i);
						next_st.ofs_en = 1'b1;
					end
				end
				WOL_CMD_OFS_EN: begin
					if (cmd_value_i[0] && speed_conflict_i) begin
						next_err = 1'b1;
					end else begin
						next_st.ofs_en = cmd_value_i[0];
					end
				end
				WOL_CMD_AC_SET: begin
					next_st.ac_mode = wol_ac_t'(cmd_value_i[1:0]);
					next_st.once_armed = 1'b1;
					if (cmd_value_i[1:0] == WOL_AC_ON) next_st.tally = WOL_TALLY_RST;
				end
				WOL_CMD_CLR_NOW: begin
					next_st.tally = WOL_TALLY_RST;
				end
				WOL_CMD_LIM_EN: begin
					next_st.lim_en = cmd_value_i[0];
				end
				WOL_CMD_LIM_LO: begin
					next_st.lim_lo = cmd_value_i;
				end
				WOL_CMD_LIM_HI: begin
					next_st.lim_hi = cmd_value_i;
				end
				default: begin
				end
			endcase
		end else if (meas_stb_i) begin
			next_st.shown = adj;
			if (meas_start_i) begin
				case (st.ac_mode)
					WOL_AC_ON: next_st.tally = WOL_TALLY_RST;
					WOL_AC_ONCE: begin
						if (st.once_armed) next_st.tally = WOL_TALLY_RST;
						next_st.once_armed = 1'b0;
					end
					default: begin
					end
				endcase
			end
			if (st.lim_en && outside) begin
				next_st.tally = TALLY_W'(next_st.tally + 1'b1);
			end
			next_st.ttl = st.lim_en && outside;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st.ofs_mag <= WOL_OFS_RST;
			st.ofs_en <= 1'b0;
			st.ac_mode <= WOL_AC_ON;
			st.once_armed <= 1'b1;
			st.lim_en <= 1'b0;
			st.lim_lo <= WOL_LIM_LO_RST;
			st.lim_hi <= WOL_LIM_HI_RST;
			st.tally <= WOL_TALLY_RST;
			st.shown <= WOL_OFS_RST;
			st.ttl <= 1'b0;
			err <= 1'b0;
		end else begin
			st <= next_st;
			err <= next_err;
		end
	end

	assign err_stb_o = err;
	assign ttl_o = st.ttl;
	assign status_o.ofs_mag = st.ofs_mag;
	assign status_o.ofs_en = st.ofs_en;
	assign status_o.ac_query = (st.ac_mode == WOL_AC_ON) ||
		((st.ac_mode == WOL_AC_ONCE) && st.once_armed);
	assign status_o.fail = (st.tally != WOL_TALLY_RST);
	assign status_o.tally = st.tally;
	assign status_o.shown = st.shown;

	a_ofs_write_enables: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_stb_i && cmd_code_i == WOL_CMD_OFS_SET && !speed_conflict_i
		|=> st.ofs_en) else $error("offset write did not enable");
	a_conflict_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_stb_i && cmd_code_i == WOL_CMD_OFS_SET && speed_conflict_i
		|=> err && $stable(st.ofs_mag)) else $error("conflict not refused");
	a_clear_now_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		cmd_stb_i && cmd_code_i == WOL_CMD_CLR_NOW |=> st.tally == 16'h0000)
		else $error("immediate clear failed");
	a_fail_after_count: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmd_stb_i && meas_stb_i && fail_now && st.tally != 16'hFFFF
		|=> status_o.fail) else $error("fail flag not raised");
	a_off_keeps_tally: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmd_stb_i && meas_stb_i && st.ac_mode == WOL_AC_OFF && !(st.lim_en && outside)
		|=> $stable(st.tally)) else $error("off mode changed tally");
	a_on_clears_start: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmd_stb_i && meas_stb_i && meas_start_i && st.ac_mode == WOL_AC_ON
		|=> st.tally == {15'h0000, $past(fail_now)})
		else $error("auto clear failed");
	a_once_disarms: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmd_stb_i && meas_stb_i && meas_start_i && st.ac_mode == WOL_AC_ONCE
		|=> !status_o.ac_query) else $error("once query wrong");
	a_tally_counts_fail: assert property (@(posedge clk_i) disable iff (rst_i)
		!cmd_stb_i && meas_stb_i && !meas_start_i && st.lim_en && outside
		|=> st.tally == $past(st.tally) + 16'h0001) else $error("tally step wrong");
	a_reset_defaults: assert property (@(posedge clk_i)
		rst_i |=> st.ac_mode == WOL_AC_ON && !st.ofs_en && st.ofs_mag == 32'sd0)
		else $error("reset values wrong");
endmodule
`default_nettype wire

// ==== verilog/wol_top.sv ====
// top: two independent window instances behind a Wishbone register file
//
// Summary of operation
// - two independent windows, upper and lower
// - offset added after the math result
// - offset range minus to plus 100 dB
// - writing offset magnitude also enables offset
// - reset zeroes offset magnitude
// - reset disables the offset
// - offset enable query reads one or zero
// - enabling offset at speed 200 errs -221
// - each window drives its limit level output
// - auto-clear on zeroes tally each start
// - auto-clear off keeps the tally
// - auto-clear once zeroes at first start
// - reset sets auto-clear on
// - auto-clear query reads one when on
// - once mode reads one until start
// - immediate clear zeroes tally anytime
// - fail reads one while tally nonzero
// - result strictly outside limits counts one
// - tally sixteen bits, wraps to zero
`timescale 1ns/1ps
`default_nettype none
module wol_top
	import wol_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic meas_stb_i,
	input wire logic meas_win_i,
	input wire logic meas_start_i,
	input wire logic signed [WOL_VAL_W-1:0] meas_value_i,
	output logic [WOL_NUM_WIN-1:0] ttl_o
);
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_SPEED = 8'h04;
	localparam logic [7:0] ADR_ERR = 8'h08;
	localparam logic [7:0] ADR_VAL = 8'h0C;
	localparam logic [7:0] ADR_W0 = 8'h10;
	localparam logic [7:0] ADR_W1 = 8'h20;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [7:0] speed;
		logic signed [15:0] err_code;
		logic [31:0] cmd_val;
		logic cmd_stb;
		logic [4:0] cmd_sel;
	} wol_top_state_t;

	wol_top_state_t s;
	wol_top_state_t next_s;
	wol_status_t stat [WOL_NUM_WIN];
	logic [WOL_NUM_WIN-1:0] err_stb;
	logic req;

	// status word: field offset 0 mag, 4 flags, 8 tally, C shown
	function automatic logic [31:0] win_read(input wol_status_t w, input logic [1:0] f);
		case (f)
			2'd0: return w.ofs_mag;
			2'd1: return {29'h0, w.fail, w.ac_query, w.ofs_en};
			2'd2: return {16'h0000, w.tally};
			default: return w.shown;
		endcase
	endfunction

	assign req = cyc_i && stb_i && !s.ack;

	always_comb begin
		next_s = s;
		next_s.ack = req;
		next_s.cmd_stb = 1'b0;
		if (err_stb != '0) next_s.err_code = WOL_ERR_CONFLICT;
		if (req && we_i) begin
			case (adr_i)
				ADR_CMD: begin
					next_s.cmd_stb = 1'b1;
					next_s.cmd_sel = dat_i[4:0];
				end
				ADR_VAL: next_s.cmd_val = dat_i;
				ADR_SPEED: if (sel_i[0]) next_s.speed = dat_i[7:0];
				ADR_ERR: if (err_stb == '0) next_s.err_code = WOL_ERR_NONE;
				default: begin
				end
			endcase
		end
		if (req) begin
			case (adr_i)
				ADR_SPEED: next_s.rdat = {24'h0, s.speed};
				ADR_ERR: next_s.rdat = {{16{s.err_code[15]}}, s.err_code};
				ADR_VAL: next_s.rdat = s.cmd_val;
				default: begin
					if (adr_i[7:4] == ADR_W0[7:4]) next_s.rdat = win_read(stat[0], adr_i[3:2]);
					else if (adr_i[7:4] == ADR_W1[7:4]) next_s.rdat = win_read(stat[1], adr_i[3:2]);
					else next_s.rdat = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ack_o = s.ack;
	assign dat_o = s.rdat;

	genvar gi;
	generate
		for (gi = 0; gi < WOL_NUM_WIN; gi++) begin : g_win
			wol_window #(
				.TALLY_W(WOL_TALLY_W)
			) u_win (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.cmd_stb_i(s.cmd_stb && (s.cmd_sel[4] == 1'(gi))),
				.cmd_code_i(wol_cmd_code_t'(s.cmd_sel[3:0])),
				.cmd_value_i(s.cmd_val),
				.speed_conflict_i(s.speed == WOL_SPEED_CONFLICT),
				.meas_stb_i(meas_stb_i && (meas_win_i == 1'(gi))),
				.meas_start_i(meas_start_i),
				.meas_value_i(meas_value_i),
				.err_stb_o(err_stb[gi]),
				.status_o(stat[gi]),
				.ttl_o(ttl_o[gi])
			);
		end
	endgenerate

	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held too long");
	a_req_acked_next: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the window offset and limit-clear block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import wol_pkg::*;
;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, dat_o, sd = 32'hB54E8FA2, r;
	logic ack_o, meas_stb_i = 0, meas_win_i = 0, meas_start_i = 0, f;
	logic signed [WOL_VAL_W-1:0] meas_value_i = 32'h0, v;
	logic signed [31:0] lo = 32'hFFFFFC18, hi = 32'h3E8;
	logic [WOL_NUM_WIN-1:0] ttl_o;
	logic [31:0] eq[$];
	logic [15:0] n = 16'h0;
	int bad_count = 0, check_count = 0;
	wol_top wol_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .meas_stb_i(meas_stb_i), .meas_win_i(meas_win_i),
		.meas_start_i(meas_start_i), .meas_value_i(meas_value_i), .ttl_o(ttl_o));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		sd = sd ^ (sd << 13);
		sd = sd ^ (sd >> 17);
		sd = sd ^ (sd << 5);
		return sd;
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		cyc_i <= 0;
		stb_i <= 0;
		if (k >= 20) begin
			bad_count++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		eq.push_back(e);
		bus(0, a, 32'h0);
	endtask
	// compares read data against the oldest noted value
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && cyc_i === 1'b1) begin
			chk("read", dat_o, eq.pop_front());
		end
	end
	task automatic cmd(input logic w, input logic [3:0] c, input logic [31:0] d);
		wr(8'h0C, d);
		wr(8'h00, {27'h0, w, c});
		repeat (3) @(posedge clk_i);
	endtask
	task automatic win(input logic w, input logic [31:0] m, input logic [2:0] s,
		input logic [15:0] t);
		logic [7:0] b;
		b = {2'h0, w, ~w, 4'h0};
		rd(b, m);
		rd(b + 8'h04, {29'h0, s});
		rd(b + 8'h08, {16'h0, t});
	endtask
	task automatic meas(input logic w, input logic st, input logic [31:0] d);
		@(posedge clk_i);
		meas_stb_i <= 1;
		meas_win_i <= w;
		meas_start_i <= st;
		meas_value_i <= d;
		@(posedge clk_i);
		meas_stb_i <= 0;
		repeat (2) @(posedge clk_i);
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		bad_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		win(0, WOL_OFS_RST, 3'h2, 16'h0);
		win(1, WOL_OFS_RST, 3'h2, 16'h0);
		rd(8'hFC, 32'h0);
		cmd(0, WOL_CMD_OFS_SET, 32'h4E20);
		win(0, 32'h4E20, 3'h3, 16'h0);
		win(1, WOL_OFS_RST, 3'h2, 16'h0);
		cmd(1, WOL_CMD_OFS_SET, 32'h249F0);
		win(1, WOL_OFS_MAX, 3'h3, 16'h0);
		cmd(1, WOL_CMD_OFS_SET, 32'hFFFDB610);
		rd(8'h20, WOL_OFS_MIN);
		cmd(1, WOL_CMD_OFS_EN, 32'h0);
		rd(8'h24, 32'h2);
		wr(8'h04, {24'h0, WOL_SPEED_CONFLICT});
		cmd(1, WOL_CMD_OFS_SET, 32'h4E20);
		rd(8'h08, 32'(WOL_ERR_CONFLICT));
		win(1, WOL_OFS_MIN, 3'h2, 16'h0);
		wr(8'h08, 32'h0);
		cmd(1, WOL_CMD_OFS_EN, 32'h1);
		rd(8'h08, 32'(WOL_ERR_CONFLICT));
		rd(8'h24, 32'h2);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h0);
		cmd(0, WOL_CMD_LIM_EN, 32'h1);
		meas(0, 0, 32'h11170);
		rd(8'h1C, WOL_LIM_HI_RST);
		win(0, 32'h4E20, 3'h3, 16'h0);
		meas(0, 0, 32'hFFFE5250);
		chk("ttl", 32'(ttl_o), 32'h0);
		meas(0, 0, 32'h11171);
		win(0, 32'h4E20, 3'h7, 16'h1);
		chk("ttl", 32'(ttl_o), 32'h1);
		meas(0, 1, 32'h11171);
		win(0, 32'h4E20, 3'h7, 16'h1);
		cmd(0, WOL_CMD_AC_SET, 32'h0);
		meas(0, 1, 32'h11171);
		win(0, 32'h4E20, 3'h5, 16'h2);
		cmd(0, WOL_CMD_AC_SET, 32'h2);
		rd(8'h14, 32'h7);
		meas(0, 1, 32'h11171);
		win(0, 32'h4E20, 3'h5, 16'h1);
		meas(0, 1, 32'h11171);
		rd(8'h18, 32'h2);
		cmd(0, WOL_CMD_CLR_NOW, 32'h0);
		win(0, 32'h4E20, 3'h1, 16'h0);
		cmd(1, WOL_CMD_LIM_EN, 32'h1);
		cmd(1, WOL_CMD_AC_SET, 32'h0);
		cmd(1, WOL_CMD_LIM_LO, lo);
		cmd(1, WOL_CMD_LIM_HI, hi);
		repeat (40) begin
			r = xs();
			v = $signed(r) >>> 20;
			f = (v < lo || v > hi);
			n = n + {15'h0, f};
			meas(1, r[0], v);
			chk("ttl", 32'(ttl_o), {30'h0, f, 1'b1});
		end
		win(1, WOL_OFS_MIN, {n != 16'h0, 2'h0}, n);
		rd(8'h18, 32'h0);
		cmd(1, WOL_CMD_AC_SET, 32'h1);
		cmd(1, WOL_CMD_OFS_EN, 32'h1);
		win(1, WOL_OFS_MIN, 3'h3, 16'h0);
		repeat (4) @(posedge clk_i);
		results();
	end
endmodule
`default_nettype wire
